// *** srr_regs.sv ***
// result, queue pop and keyed restart register bank
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Summary of operation
// - z low register returns the six low bits of the 14-bit value in [7:2].
// - temperature is split into a high byte and six low bits in [7:2].
// - aux converter result is split into a high byte and six low bits in [7:2].
// - a direct read of the pop port removes one queue entry.
// - one entry is delivered over two byte reads; further reads pop again.
// - a burst started at the pop port keeps the pointer on the pop port.
// - incrementing into the pop port from below skips it without a pop.
// - writing 0x52 to the restart register restarts the device at once.
// - on restart the pointer, pop phase, latched low byte, read answer and pin drives return to default.
// - after restart interrupt pins float, held by keepers, unless driven.
// - the restart register is write-only and always reads 0x00.
// ---------------------------------------------------------------
module srr_regs
  import srr_pkg::*;
#(
  parameter int SRST_WAIT = SRST_WAIT_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire srr_req_t req_in,
  input wire srr_results_t results_in,
  input wire logic [ENTRY_W-1:0] fifo_data_in,
  output logic fifo_pop_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [7:0] addr_ptr_out,
  output logic busy_out,
  output logic soft_reset_out,
  input wire logic [INT_PINS-1:0] int_drive_in,
  input wire logic [INT_PINS-1:0] int_level_in,
  output logic [INT_PINS-1:0] int_pin_out,
  output logic [INT_PINS-1:0] int_pin_oe_out,
  output logic [INT_PINS-1:0] keeper_en_out
);

  // ---------------------------------------------------------------
  // reset
  // ---------------------------------------------------------------
  logic rst_n;

  srr_reset_sync u_rst (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .rst_n_out(rst_n)
  );

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic [7:0] ptr_r;
  srr_phase_t phase_r;
  logic [7:0] pop_low_r;
  logic [BUSY_W-1:0] busy_cnt_r;
  logic [7:0] rd_nxt;
  logic rd_go;
  logic wr_go;
  logic pop_go;
  logic restart_fire;

  // a start moves the pointer and resets the pop phase; accesses wait for the next cycle
  assign rd_go = req_in.rd && !req_in.start && !busy_out;
  assign wr_go = req_in.wr && !req_in.rd && !req_in.start && !busy_out;
  // only the first byte of a pair pops
  assign pop_go = rd_go && (ptr_r == ADDR_POP) && (phase_r == PH_FIRST);
  assign restart_fire = wr_go && (ptr_r == ADDR_RESTART)
                        && (req_in.wdata == RESTART_KEY);
  assign fifo_pop_out = pop_go;
  assign busy_out = (busy_cnt_r != '0);
  assign addr_ptr_out = ptr_r;

  // ---------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------
  always_comb begin
    case (ptr_r)
      ADDR_Z_LOW: begin
        rd_nxt = low_bits(results_in.z);
      end
      ADDR_TEMP_HIGH: begin
        rd_nxt = high_byte(results_in.temp);
      end
      ADDR_TEMP_LOW: begin
        rd_nxt = low_bits(results_in.temp);
      end
      ADDR_AUX_HIGH: begin
        rd_nxt = high_byte(results_in.aux);
      end
      ADDR_AUX_LOW: begin
        rd_nxt = low_bits(results_in.aux);
      end
      ADDR_POP: begin
        // high byte first, low byte from the latch of the same entry
        if (phase_r == PH_FIRST) begin
          rd_nxt = fifo_data_in[15:8];
        end else begin
          rd_nxt = pop_low_r;
        end
      end
      ADDR_RESTART: begin
        rd_nxt = READ_ZERO;
      end
      default: begin
        rd_nxt = READ_ZERO;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // address pointer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= PTR_RESET;
    end else if (restart_fire) begin
      ptr_r <= PTR_RESET;
    end else if (req_in.start && !busy_out) begin
      ptr_r <= req_in.addr;
    end else if (rd_go || wr_go) begin
      ptr_r <= next_ptr(ptr_r);
    end
  end

  // ---------------------------------------------------------------
  // pop pairing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_FIRST;
    end else if (restart_fire || (req_in.start && !busy_out)) begin
      phase_r <= PH_FIRST;
    end else if (rd_go && (ptr_r == ADDR_POP)) begin
      // toggling keeps later reads popping later entries
      phase_r <= (phase_r == PH_FIRST) ? PH_SECOND : PH_FIRST;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pop_low_r <= BYTE_RESET;
    end else if (restart_fire) begin
      pop_low_r <= BYTE_RESET;
    end else if (pop_go) begin
      pop_low_r <= fifo_data_in[7:0];
    end
  end

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  // writes to read-only offsets fall through: nothing here stores them
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= BYTE_RESET;
      rvalid_out <= 1'b0;
    end else if (restart_fire) begin
      rdata_out <= BYTE_RESET;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_go;
      if (rd_go) begin
        rdata_out <= rd_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // keyed restart
  // ---------------------------------------------------------------
  // the busy window covers the restart latency so a hasty host is ignored
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_out <= 1'b0;
      busy_cnt_r <= '0;
    end else begin
      soft_reset_out <= restart_fire;
      if (restart_fire) begin
        busy_cnt_r <= BUSY_W'(SRST_WAIT);
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= BUSY_W'(busy_cnt_r - 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin control
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_pin_oe_out <= '0;
      int_pin_out <= '0;
    end else if (restart_fire || busy_out) begin
      int_pin_oe_out <= '0;
      int_pin_out <= '0;
    end else begin
      int_pin_oe_out <= int_drive_in;
      int_pin_out <= int_level_in & int_drive_in;
    end
  end

  // keepers hold the level whenever nobody drives the pin
  assign keeper_en_out = ~int_pin_oe_out;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence pop_read_s;
    fifo_pop_out ##1 rd_go;
  endsequence

  sequence restart_s;
    soft_reset_out && busy_out;
  endsequence

  pop_on_port_a: assert property (
    fifo_pop_out |-> (ptr_r == ADDR_POP) && !busy_out && req_in.rd)
    else $error("pop outside a direct read of the pop port");

  pop_high_byte_a: assert property (
    fifo_pop_out |=> rvalid_out && (rdata_out == $past(fifo_data_in[15:8])))
    else $error("first byte of a popped entry is wrong");

  pop_pair_a: assert property (
    pop_read_s |-> !fifo_pop_out ##1 (rdata_out == $past(pop_low_r)))
    else $error("second byte popped or delivered the wrong value");

  ptr_hold_a: assert property (
    (rd_go && (ptr_r == ADDR_POP)) |=> (ptr_r == ADDR_POP))
    else $error("pointer left the pop port during a burst");

  skip_pop_a: assert property (
    (rd_go && (ptr_r == ADDR_AUX_LOW)) |=> (ptr_r == ADDR_AFTER_POP))
    else $error("increment did not skip the pop port");

  restart_fire_a: assert property (
    restart_fire |=> restart_s ##1 busy_out[*8])
    else $error("key write did not start the restart");

  restart_clear_a: assert property (
    soft_reset_out |-> (ptr_r == PTR_RESET) && (phase_r == PH_FIRST)
      && !rvalid_out)
    else $error("state not returned to default on restart");

  pins_float_a: assert property (
    soft_reset_out |-> (int_pin_oe_out == '0) && (keeper_en_out == '1))
    else $error("interrupt pins still driven after restart");

  restart_reads_zero_a: assert property (
    (rd_go && (ptr_r == ADDR_RESTART)) |=> (rdata_out == READ_ZERO))
    else $error("restart register read was not zero");

  temp_split_a: assert property (
    (rd_go && (ptr_r == ADDR_TEMP_HIGH))
      |=> (rdata_out == $past(results_in.temp[13:6])))
    else $error("temperature high byte wrong");

  aux_low_a: assert property (
    (rd_go && (ptr_r == ADDR_AUX_LOW))
      |=> (rdata_out == {$past(results_in.aux[5:0]), 2'b00}))
    else $error("aux low bits wrong");

  z_low_a: assert property (
    (rd_go && (ptr_r == ADDR_Z_LOW))
      |=> (rdata_out[7:2] == $past(results_in.z[5:0]))
      && (rdata_out[1:0] == 2'b00))
    else $error("z low bits wrong");

  aux_high_a: assert property (
    (rd_go && (ptr_r == ADDR_AUX_HIGH))
      |=> (rdata_out == $past(results_in.aux[13:6])))
    else $error("aux high byte wrong");

  temp_low_a: assert property (
    (rd_go && (ptr_r == ADDR_TEMP_LOW))
      |=> (rdata_out == {$past(results_in.temp[5:0]), 2'b00}))
    else $error("temperature low bits wrong");

  second_no_pop_a: assert property (
    (rd_go && (ptr_r == ADDR_POP) && (phase_r == PH_SECOND))
      |-> !fifo_pop_out)
    else $error("second byte of a pair popped the queue");

  pop_latch_a: assert property (
    fifo_pop_out |=> (pop_low_r == $past(fifo_data_in[7:0])))
    else $error("low byte of the popped entry not kept");

  skip_no_pop_a: assert property (
    (rd_go && (ptr_r == ADDR_AUX_LOW)) |=> !fifo_pop_out)
    else $error("increment into the pop port popped the queue");

  wrong_key_a: assert property (
    (wr_go && (ptr_r == ADDR_RESTART) && (req_in.wdata != RESTART_KEY))
      |=> !soft_reset_out)
    else $error("restart without the key");

  busy_refuse_a: assert property (
    busy_out |-> !fifo_pop_out ##1 !rvalid_out)
    else $error("request taken during the restart latency");

  pins_follow_a: assert property (
    (!busy_out && !restart_fire)
      |=> (int_pin_oe_out == $past(int_drive_in)))
    else $error("interrupt pin enable does not follow its source");

endmodule : srr_regs

// *** srr_pkg.sv ***
// package of constants and carrier types for the result and restart registers
package srr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_Z_LOW = 8'h13;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h14;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h15;
  localparam logic [7:0] ADDR_AUX_HIGH = 8'h16;
  localparam logic [7:0] ADDR_AUX_LOW = 8'h17;
  localparam logic [7:0] ADDR_POP = 8'h18;
  localparam logic [7:0] ADDR_AFTER_POP = 8'h19;
  localparam logic [7:0] ADDR_RESTART = 8'h1F;

  // ---------------------------------------------------------------
  // values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RESTART_KEY = 8'h52;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int RES_W = 14;
  localparam int ENTRY_W = 16;
  localparam int INT_PINS = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SRST_WAIT_NS = 500000;
  localparam int SRST_WAIT_CYC = SRST_WAIT_NS / CLK_PERIOD_NS;
  localparam int BUSY_W = 16;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srr_req_t;

  typedef struct packed {
    logic [RES_W-1:0] z;
    logic [RES_W-1:0] temp;
    logic [RES_W-1:0] aux;
  } srr_results_t;

  typedef enum logic {
    PH_FIRST = 1'b0,
    PH_SECOND = 1'b1
  } srr_phase_t;

  // ---------------------------------------------------------------
  // field helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] high_byte(input logic [RES_W-1:0] v);
    high_byte = v[13:6];
  endfunction : high_byte

  function automatic logic [7:0] low_bits(input logic [RES_W-1:0] v);
    low_bits = {v[5:0], 2'b00};
  endfunction : low_bits

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    if (p == ADDR_POP) begin
      next_ptr = ADDR_POP;
    end else if (p == ADDR_AUX_LOW) begin
      next_ptr = ADDR_AFTER_POP;
    end else begin
      next_ptr = 8'(p + 8'h01);
    end
  endfunction : next_ptr

endpackage : srr_pkg

// *** srr_reset_sync.sv ***
// reset release synchroniser
`timescale 1ns/1ns
module srr_reset_sync
  import srr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  output logic rst_n_out
);

  logic meta_r;
  logic hold_r;

  // assert at once, release after two edges
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      hold_r <= meta_r;
    end
  end

  assign rst_n_out = hold_r;

endmodule : srr_reset_sync

// *** srr_host.sv ***
// host model driving the register access port
`timescale 1ns/1ns
module srr_host
  import srr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic busy_in,
  output srr_req_t req_out
);
  // ---------------------------------------------------------------
  // requests
  // ---------------------------------------------------------------
  initial req_out = '0;

  // called 1 ns after an edge; holds the request across one edge
  task automatic put(input logic s, r, w, input logic [7:0] a, d);
    req_out = '{s, r, w, a, d};
    @(posedge sys_clk_in);
    #1;
  endtask : put

  // host waits until the restart latency ends or n reaches 1000; the last request stays on the port meanwhile
  task automatic wait_idle(output int n);
    n = 1;
    while (busy_in === 1'b1 && n < 1000) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
  endtask : wait_idle
endmodule : srr_host

// *** srr_regs_tb.sv ***
// self-checking bench for the result and restart register bank
`timescale 1ns/1ns
module srr_regs_tb;
  import srr_pkg::*;
  localparam int WAIT = 20;
  logic sys_clk, reset_n, fifo_pop, rvalid, busy, srst;
  srr_req_t req;
  srr_results_t res;
  logic [15:0] head = 16'hA5C3;
  logic [15:0] held;
  logic [7:0] rdata, ptr;
  logic [1:0] drv, lvl, pin, oe, keep;
  int errors = 0, check_count = 0, pops = 0, seed = 59028, n;
  logic [7:0] exp_q[$];

  srr_regs #(.SRST_WAIT(WAIT)) dut_u (.sys_clk_in(sys_clk),
    .reset_n_in(reset_n), .req_in(req), .results_in(res),
    .fifo_data_in(head), .fifo_pop_out(fifo_pop), .rdata_out(rdata),
    .rvalid_out(rvalid), .addr_ptr_out(ptr), .busy_out(busy),
    .soft_reset_out(srst), .int_drive_in(drv), .int_level_in(lvl),
    .int_pin_out(pin), .int_pin_oe_out(oe), .keeper_en_out(keep));
  srr_host host_u (.sys_clk_in(sys_clk), .busy_in(busy), .req_out(req));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    host_u.put(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
  endtask : rd

  // queue head model: a new entry follows every pop
  always @(posedge sys_clk) begin
    if (fifo_pop === 1'b1) begin
      pops++;
      head <= 16'($random(seed));
    end
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk(rdata, 16'hFFFF, "unexpected read");
      else
        chk(rdata, exp_q.pop_front(), "read data");
    end
    if (reset_n === 1'b1)
      chk(keep ^ oe, 16'h0003, "keeper");
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    drv = 2'b00;
    lvl = 2'b00;
    res = '0;
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(rdata, 16'h0000, "rdata reset");
    res.z = 14'($random(seed));
    res.temp = 14'($random(seed));
    res.aux = 14'($random(seed));
    drv = 2'($random(seed));
    lvl = 2'($random(seed));
    // z high lives outside this bank and reads as zero here
    host_u.put(1'b1, 1'b0, 1'b0, 8'(ADDR_Z_LOW - 8'h01), 8'h00);
    rd(8'h00);
    rd({res.z[5:0], 2'b00});
    rd(res.temp[13:6]);
    rd({res.temp[5:0], 2'b00});
    rd(res.aux[13:6]);
    rd({res.aux[5:0], 2'b00});
    rd(8'h00);
    host_u.put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(16'(pops), 16'h0000, "skip pop");
    chk(ptr, 16'h001A, "skip pointer");
    $display("test burst done");
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_POP, 8'h00);
    for (int i = 0; i < 2; i++) begin
      held = head;
      rd(held[15:8]);
      rd(held[7:0]);
    end
    held = head;
    rd(held[15:8]);
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_POP, 8'h00);
    held = head;
    rd(held[15:8]);
    host_u.put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(16'(pops), 16'h0004, "pop count");
    chk(ptr, ADDR_POP, "pop pointer");
    $display("test pop done");
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_RESTART, 8'h00);
    rd(8'h00);
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_Z_LOW, 8'h00);
    host_u.put(1'b0, 1'b0, 1'b1, 8'h00, 8'hFF);
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_Z_LOW, 8'h00);
    rd({res.z[5:0], 2'b00});
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_RESTART, 8'h00);
    host_u.put(1'b0, 1'b0, 1'b1, 8'h00, 8'h51);
    chk(srst, 16'h0000, "wrong key");
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_RESTART, 8'h00);
    host_u.put(1'b0, 1'b0, 1'b1, 8'h00, RESTART_KEY);
    chk({srst, busy}, 16'h0003, "restart");
    chk(ptr, PTR_RESET, "restart pointer");
    chk(rdata, 16'h0000, "restart rdata");
    chk(keep, 16'h0003, "restart keeper");
    // refused while busy: any answer is flagged by the monitor
    host_u.put(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    host_u.wait_idle(n);
    chk(16'(n), 16'(WAIT), "busy span");
    host_u.put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(oe, drv, "pin enable");
    chk(pin, drv & lvl, "pin level");
    host_u.put(1'b1, 1'b0, 1'b0, ADDR_AUX_HIGH, 8'h00);
    rd(res.aux[13:6]);
    host_u.put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000, "missing reads");
    $display("test restart done");
    conclude();
  end
endmodule : srr_regs_tb
